// ===== sre_ret_stack.sv
`timescale 1ns/1ps
`default_nettype none

// circular return-address stack; top entry comes out of a register
module sre_ret_stack #(
   parameter int PTR_W = 1,
   parameter int ADDR_W = 1
) (
   input wire logic clk, // core clock
   input wire logic rst_n, // synchronised reset, active low
   input wire logic push, // save an address
   input wire logic [ADDR_W-1:0] push_data, // address to save
   input wire logic pop, // discard the top entry
   output logic [ADDR_W-1:0] top_r // current top entry, registered
);

   logic [ADDR_W-1:0] mem [0:(1<<PTR_W)-1];
   logic [PTR_W-1:0] ptr_r;

   // storage; no reset so it maps onto plain ram cells
   always_ff @(posedge clk) begin
      if (push && !pop) begin
         mem[ptr_r] <= push_data;
      end
   end

   // pointer wraps silently: overflow and underflow are not flagged
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ptr_r <= '0;
      end else if (pop) begin
         ptr_r <= ptr_r - PTR_W'(1);
      end else if (push) begin
         ptr_r <= ptr_r + PTR_W'(1);
      end
   end

   // registered read lags one edge behind a push or pop
   always_ff @(posedge clk) begin
      top_r <= mem[ptr_r - PTR_W'(1)];
   end

endmodule

`default_nettype wire

// ===== sre_return_exec.sv
// What this block does
// RQ1: the plain return pops one level off the return-address stack, dropping that entry.
// RQ2: the stack top entry is copied into the program counter so fetch resumes at the return point.
// RQ3: each return takes two instruction cycles, the second being an idle flush in all four phases.
// RQ4: the plain return decodes in phase one, idles in phases two and three, and pops in phase four.
// RQ5: the literal return writes the accumulator and pops the stack together in phase four.
// RQ6: the literal return loads its 8-bit literal into the accumulator and reloads the program counter.
// RQ7: no status flag changes, and the accumulator changes only for the literal return.
`timescale 1ns/1ps
`default_nettype none

package sre_pkg;
   localparam int INSTR_W = 14;
   localparam int ADDR_W = 13;
   localparam int LIT_W = 8;
   localparam int STK_PTR_W = 3;
   localparam int NUM_PHASES = 4;
   // opcode patterns
   localparam logic [INSTR_W-1:0] OP_RETURN = 14'h0008;
   localparam int LITOP_MSB = 13;
   localparam int LITOP_LSB = 10;
   localparam logic [3:0] OP_RETLIT_HI = 4'hD;
   // quarter phase codes, one-hot, rotating left
   localparam logic [NUM_PHASES-1:0] PH_Q1 = 4'h1;
   localparam logic [NUM_PHASES-1:0] PH_Q2 = 4'h2;
   localparam logic [NUM_PHASES-1:0] PH_Q4 = 4'h8;
   localparam logic [ADDR_W-1:0] PC_RST = 13'h0000;
   localparam logic [LIT_W-1:0] W_RST = 8'h00;

   typedef enum logic [2:0] {
      SRE_IDLE = 3'h1,
      SRE_EXEC = 3'h2,
      SRE_FLUSH = 3'h4
   } sre_state_e;

   function automatic logic sre_is_ret(input logic [INSTR_W-1:0] op);
      return op == OP_RETURN;
   endfunction

   function automatic logic sre_is_retlit(input logic [INSTR_W-1:0] op);
      return op[LITOP_MSB:LITOP_LSB] == OP_RETLIT_HI;
   endfunction
endpackage

module sre_return_exec
   import sre_pkg::*;
(
   input wire logic sys_clk, // core clock, 100 MHz
   input wire logic arst_n, // async reset, active low
   input wire logic [INSTR_W-1:0] instr_word, // fetched opcode, valid in phase one
   input wire logic instr_valid, // opcode present this cycle
   input wire logic push_en, // call logic saves an address
   input wire logic [ADDR_W-1:0] push_addr, // address saved by a call
   output logic [NUM_PHASES-1:0] phase_r, // current quarter phase, one-hot
   output logic busy_r, // a return is in progress
   output logic flush_r, // second cycle: fetched opcode discarded
   output logic pc_load_r, // one-cycle strobe to reload the pc
   output logic [ADDR_W-1:0] pc_value_r, // new pc value
   output logic w_load_r, // one-cycle strobe to write the accumulator
   output logic [LIT_W-1:0] w_value_r, // accumulator value
   output logic flag_we_r // status flag write enable, never raised here
);

   ////////////////////////////////////////////////////////////////////////////////
   // reset release and phase clock

   logic [1:0] rst_sync_r;
   logic rst_n;
   assign rst_n = rst_sync_r[1];

   // release through two flops so all flops leave reset on one edge
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end

   // one clock per quarter phase
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_r <= PH_Q1;
      end else begin
         phase_r <= {phase_r[NUM_PHASES-2:0], phase_r[NUM_PHASES-1]};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sequencer

   sre_state_e state_r;
   sre_state_e state_nxt;
   logic is_lit_r;
   logic [LIT_W-1:0] lit_r;
   logic stk_pop;
   logic [ADDR_W-1:0] stk_top;

   wire q1 = phase_r == PH_Q1;
   wire q4 = phase_r == PH_Q4;
   wire dec_hit = instr_valid && (sre_is_ret(instr_word) || sre_is_retlit(instr_word));

   // decode in phase one only, pop in phase four, then one idle cycle
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         SRE_IDLE: begin
            if (q1 && dec_hit) begin
               state_nxt = SRE_EXEC; // RQ4
            end
         end
         SRE_EXEC: begin
            if (q4) begin
               state_nxt = SRE_FLUSH; // RQ3
            end
         end
         SRE_FLUSH: begin
            if (q4) begin
               state_nxt = SRE_IDLE; // RQ3
            end
         end
         default: begin
            state_nxt = SRE_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= SRE_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // kind and literal both captured at decode in phase one
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         is_lit_r <= 1'b0;
         lit_r <= W_RST;
      end else begin
         if (state_r == SRE_IDLE && q1 && dec_hit) begin
            is_lit_r <= sre_is_retlit(instr_word);
            lit_r <= instr_word[LIT_W-1:0];
         end
      end
   end

   // phases two and three of the first cycle do nothing
   assign stk_pop = (state_r == SRE_EXEC) && q4; // RQ1

   ////////////////////////////////////////////////////////////////////////////////
   // stack and outputs

   sre_ret_stack #(
      .PTR_W(STK_PTR_W),
      .ADDR_W(ADDR_W)
   ) u_stack (
      .clk(sys_clk),
      .rst_n(rst_n),
      .push(push_en),
      .push_data(push_addr),
      .pop(stk_pop),
      .top_r(stk_top)
   );

   // pc reload and accumulator write share the pop edge
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pc_load_r <= 1'b0;
         pc_value_r <= PC_RST;
         w_load_r <= 1'b0;
         w_value_r <= W_RST;
      end else begin
         pc_load_r <= stk_pop; // RQ2
         w_load_r <= stk_pop && is_lit_r; // RQ5
         if (stk_pop) begin
            pc_value_r <= stk_top; // RQ2
         end
         if (stk_pop && is_lit_r) begin
            w_value_r <= lit_r; // RQ6
         end
      end
   end

   // status lines; flags are never written by a return
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_r <= 1'b0;
         flush_r <= 1'b0;
         flag_we_r <= 1'b0;
      end else begin
         busy_r <= state_nxt != SRE_IDLE;
         flush_r <= state_nxt == SRE_FLUSH; // RQ3
         flag_we_r <= 1'b0; // RQ7
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   property p_pop_once;
      @(posedge sys_clk) disable iff (!rst_n)
      $rose(busy_r) |-> ##2 stk_pop ##1 !stk_pop [*4];
   endproperty
   a_pop_once: assert property (p_pop_once) else $error("pop not in fourth phase"); // RQ1

   property p_pc_from_top;
      @(posedge sys_clk) disable iff (!rst_n)
      stk_pop |=> pc_load_r && pc_value_r == $past(stk_top);
   endproperty
   a_pc_from_top: assert property (p_pc_from_top) else $error("pc not loaded from top"); // RQ2

   property p_two_cycles;
      @(posedge sys_clk) disable iff (!rst_n)
      $rose(busy_r) |-> busy_r [*7] ##1 !busy_r;
   endproperty
   a_two_cycles: assert property (p_two_cycles) else $error("return not two cycles"); // RQ3

   property p_flush_len;
      @(posedge sys_clk) disable iff (!rst_n)
      $rose(flush_r) |-> pc_load_r ##1 (flush_r && !pc_load_r && !w_load_r) [*3] ##1 !flush_r;
   endproperty
   a_flush_len: assert property (p_flush_len) else $error("flush cycle wrong"); // RQ3

   property p_decode_q1;
      @(posedge sys_clk) disable iff (!rst_n)
      $rose(busy_r) |-> $past(q1) && $past(dec_hit);
   endproperty
   a_decode_q1: assert property (p_decode_q1) else $error("decode outside phase one"); // RQ4

   property p_w_with_pop;
      @(posedge sys_clk) disable iff (!rst_n)
      w_load_r |-> pc_load_r && $past(q4);
   endproperty
   a_w_with_pop: assert property (p_w_with_pop) else $error("w write not with pop"); // RQ5

   property p_w_literal;
      @(posedge sys_clk) disable iff (!rst_n)
      w_load_r |-> w_value_r == $past(lit_r, 1) && $past(is_lit_r);
   endproperty
   a_w_literal: assert property (p_w_literal) else $error("w not the literal"); // RQ6

   property p_no_side_effects;
      @(posedge sys_clk) disable iff (!rst_n)
      !flag_we_r and ((pc_load_r && !$past(is_lit_r)) |-> !w_load_r && $stable(w_value_r));
   endproperty
   a_no_side_effects: assert property (p_no_side_effects) else $error("flags or w touched"); // RQ7

endmodule

`default_nettype wire

// ===== tb_sre_return_exec.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import sre_pkg::*;
   logic sys_clk, arst_n, instr_valid, push_en;
   logic [INSTR_W-1:0] instr_word;
   logic [ADDR_W-1:0] push_addr, pc_value_r;
   logic [NUM_PHASES-1:0] phase_r;
   logic busy_r, flush_r, pc_load_r, w_load_r, flag_we_r;
   logic [LIT_W-1:0] w_value_r;
   int failures, n_tests;

   sre_return_exec sre_return_exec_i (.sys_clk(sys_clk), .arst_n(arst_n),
      .instr_word(instr_word), .instr_valid(instr_valid), .push_en(push_en),
      .push_addr(push_addr), .phase_r(phase_r), .busy_r(busy_r), .flush_r(flush_r),
      .pc_load_r(pc_load_r), .pc_value_r(pc_value_r), .w_load_r(w_load_r),
      .w_value_r(w_value_r), .flag_we_r(flag_we_r));

   ////////////////////////////////////////////////////////////////////////////////
   // clock and shared helpers
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checks=%0d mismatches=%0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // stop mid-cycle in phase four, so the next edge opens phase one
   task automatic wait_q4();
      for (int n = 0; n < 16; n++) begin
         @(posedge sys_clk);
         #1;
         if (phase_r === 4'h8) break;
      end
   endtask

   // push at least two clocks ahead of any pop, the top read is registered
   task automatic push(input logic [ADDR_W-1:0] a);
      @(posedge sys_clk);
      push_en <= 1'b1;
      push_addr <= a;
      @(posedge sys_clk);
      push_en <= 1'b0;
      repeat (2) @(posedge sys_clk);
   endtask

   // one return; nxt is offered from phase one of the flush, while still busy
   task automatic run_ret(input logic [INSTR_W-1:0] op, input logic [INSTR_W-1:0] nxt,
      input logic [ADDR_W-1:0] exp_pc, input logic lit, input logic [LIT_W-1:0] exp_w,
      input logic aligned);
      if (!aligned) begin
         wait_q4();
         @(posedge sys_clk);
         instr_word <= op;
         instr_valid <= 1'b1;
      end
      @(posedge sys_clk);
      instr_valid <= 1'b0;
      instr_word <= 14'h3FFF;
      for (int i = 1; i <= 8; i++) begin
         if (i > 1) @(posedge sys_clk);
         if (i == 4 && nxt != '0) begin
            instr_word <= nxt;
            instr_valid <= 1'b1;
         end
         #1;
         chk(busy_r, i < 8);
         chk(flush_r, i >= 4 && i < 8);
         chk(pc_load_r, i == 4);
         chk(w_load_r, lit && i == 4);
         chk(flag_we_r, 1'b0);
         chk(phase_r, 4'h1 << (i % 4));
         if (i == 4) chk(pc_value_r, exp_pc);
         if (i == 4) chk(w_value_r, exp_w);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_plain();
      push(13'h1ABC);
      push(13'h0123);
      run_ret(OP_RETURN, '0, 13'h0123, 1'b0, 8'h00, 1'b0);
      run_ret(OP_RETURN, '0, 13'h1ABC, 1'b0, 8'h00, 1'b0);
      $display("plain return done");
   endtask

   // literal returns back to back, the second with don't-care bits set
   task automatic t_literal();
      push(13'h1FFF);
      push(13'h0055);
      push(13'h0AAA);
      run_ret(14'h34A5, 14'h375A, 13'h0AAA, 1'b1, 8'hA5, 1'b0);
      run_ret(14'h375A, '0, 13'h0055, 1'b1, 8'h5A, 1'b1);
      run_ret(OP_RETURN, '0, 13'h1FFF, 1'b0, 8'h5A, 1'b0);
      $display("literal return done");
   endtask

   // neither a non-return opcode nor a return seen outside phase one starts anything
   task automatic t_ignore();
      wait_q4();
      @(posedge sys_clk);
      instr_word <= 14'h0009;
      instr_valid <= 1'b1;
      @(posedge sys_clk);
      instr_word <= OP_RETURN;
      @(posedge sys_clk);
      instr_valid <= 1'b0;
      repeat (8) begin
         @(posedge sys_clk);
         #1;
         chk(busy_r, 1'b0);
         chk(pc_load_r | w_load_r, 1'b0);
      end
      $display("ignored opcode done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence and watchdog
   initial begin
      arst_n = 1'b0;
      instr_valid = 1'b0;
      instr_word = 14'h3FFF;
      push_en = 1'b0;
      push_addr = '0;
      failures = 0;
      n_tests = 0;
      repeat (2) @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      t_plain();
      t_literal();
      t_ignore();
      end_of_test();
   end

   // tests need about a hundred clocks; far longer means a hang
   initial begin
      #50000;
      failures++;
      end_of_test();
   end
endmodule

`default_nettype wire
